// ### rtl/tstc_regs.svh
// register offsets, reset values, field positions and timing counts
`ifndef TSTC_REGS_SVH
`define TSTC_REGS_SVH
// register indexes; byte address is four times the index
`define TSTC_IDX_INCLUDE    8'h21
`define TSTC_IDX_HOLD       8'h23
`define TSTC_IDX_SAMPLING   8'h24
`define TSTC_IDX_RECAL      8'h26
`define TSTC_IDX_REPEAT     8'h28
`define TSTC_IDX_STATUS     8'h30
`define TSTC_IDX_CALCODE0   8'h40
`define TSTC_IDX_MEAS0      8'h50
// reset values
`define TSTC_RST_INCLUDE    8'h3F
`define TSTC_RST_HOLD       8'h07
`define TSTC_RST_SAMPLING   8'h39
`define TSTC_RST_RECAL      8'h00
`define TSTC_RST_REPEAT     8'h3F
// field positions
`define TSTC_HOLD_MSB       3
`define TSTC_AVG_MSB        6
`define TSTC_AVG_LSB        4
`define TSTC_SAMP_MSB       3
`define TSTC_SAMP_LSB       2
`define TSTC_CYC_MSB        1
`define TSTC_CYC_LSB        0
// timebase: clock period and tick period
`define TSTC_CLK_NS         25
`define TSTC_TICK_NS        5000
`define TSTC_TICK_CYC       (`TSTC_TICK_NS / `TSTC_CLK_NS)
// durations in their own units, then in ticks
`define TSTC_HOLD_STEP_MS   35
`define TSTC_CYC_STEP_MS    35
`define TSTC_SAMP_BASE_US   320
`define TSTC_RECAL_MAX_MS   600
`define TSTC_HOLD_STEP_TK   (`TSTC_HOLD_STEP_MS * 1000000 / `TSTC_TICK_NS)
`define TSTC_CYC_STEP_TK    (`TSTC_CYC_STEP_MS * 1000000 / `TSTC_TICK_NS)
`define TSTC_SAMP_BASE_TK   (`TSTC_SAMP_BASE_US * 1000 / `TSTC_TICK_NS)
`define TSTC_RECAL_MAX_TK   (`TSTC_RECAL_MAX_MS * 1000000 / `TSTC_TICK_NS)
`endif

// ### rtl/tstc_pkg.sv
// types shared by the touch sampling timing controller
`default_nettype none
package tstc_pkg;
  // sampling sequencer states
  typedef enum logic [0:0] {
    ST_SAMPLE,
    ST_LOWPWR
  } tstc_state_t;
endpackage
`default_nettype wire

// ### rtl/tstc_tick.sv
// fixed timebase tick generator
`default_nettype none
module tstc_tick #(
  parameter int unsigned TICK_CYC = 200
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  output logic      tick
);
  logic [15:0] cnt_q;  // cycles since last tick
  logic [15:0] cnt_d;
  logic        last;   // final cycle of tick period
  logic        tick_q;

  assign last  = (cnt_q == 16'(TICK_CYC - 1));
  assign cnt_d = last ? 16'h0000 : cnt_q + 16'h0001;
  assign tick  = tick_q;

  // divider and one-cycle tick pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= last;
    end
  end
endmodule
`default_nettype wire

// ### rtl/tstc_core.sv
// touch sampling timing controller: registers, sequencer, hold timer, recalibration
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "tstc_regs.svh"
`default_nettype none
module tstc_core
  import tstc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `TSTC_TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [5:0]  pad_touch,
  input  wire logic [15:0] afe_sample_value,
  input  wire logic        afe_cal_done,
  input  wire logic [9:0]  afe_cal_code,
  output logic             afe_sample_go,
  output logic      [2:0]  afe_channel,
  output logic             afe_low_power,
  output logic             afe_cal_start,
  output logic      [2:0]  afe_cal_channel,
  output logic      [5:0]  recal_active,
  output logic             meas_valid,
  output logic      [2:0]  meas_channel,
  output logic      [15:0] meas_value,
  output logic      [5:0]  touch_event,
  output logic      [5:0]  hold_event
);
  // tick-count decodes
  function automatic logic [16:0] hold_limit(input logic [3:0] code);
    hold_limit = 17'(({13'h0000, code} + 17'h00001) * `TSTC_HOLD_STEP_TK);
  endfunction
  function automatic logic [19:0] cyc_limit(input logic [1:0] code);
    cyc_limit = 20'(({18'h00000, code} + 20'h00001) * `TSTC_CYC_STEP_TK);
  endfunction
  function automatic logic [9:0] samp_ticks(input logic [1:0] code);
    samp_ticks = 10'(`TSTC_SAMP_BASE_TK) << code;
  endfunction
  // first set bit at or above a start index: {found, index}
  function automatic logic [3:0] first_from(input logic [5:0] bits, input logic [3:0] from);
    first_from = 4'h0;
    for (int i = 5; i >= 0; i--)
      if (bits[i] && (4'(i) >= from))
        first_from = {1'b1, 3'(i)};
  endfunction

  logic tick;  // timebase tick
  tstc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  // ---------------- register bus ----------------
  logic [5:0]  include_q;            // inputs in the sampling cycle
  logic [3:0]  hold_q;               // minimum hold code
  logic [6:0]  sampling_q;           // avg, sample time, cycle time
  logic [5:0]  cal_req_q;            // recalibration requests
  logic [5:0]  repeat_q;             // repeat enables
  logic [9:0]  cal_code_q [6];       // per input calibration code
  logic [15:0] meas_q [6];           // per input averaged result
  logic        wait_q;               // registered waitrequest
  logic [31:0] rdata_q;
  logic        req;                  // request present
  logic        bus_wr;               // write takes effect this edge
  logic [31:0] rd_mux;
  logic [2:0]  rd_ix;                // index into per input arrays
  logic        rd_cal;
  logic        rd_meas;
  logic [5:0]  rc_clr;               // hardware clear of request bits

  assign req     = avs_read | avs_write;
  assign bus_wr  = avs_write & ~wait_q;
  assign rd_ix   = avs_address[2:0];
  assign rd_cal  = (avs_address[7:3] == `TSTC_IDX_CALCODE0 >> 3) && (rd_ix < 3'h6);
  assign rd_meas = (avs_address[7:3] == `TSTC_IDX_MEAS0 >> 3) && (rd_ix < 3'h6);
  assign rd_mux  =
    (avs_address == `TSTC_IDX_INCLUDE)  ? {26'h0000000, include_q} :
    (avs_address == `TSTC_IDX_HOLD)     ? {28'h0000000, hold_q} :
    (avs_address == `TSTC_IDX_SAMPLING) ? {25'h0000000, sampling_q} :
    (avs_address == `TSTC_IDX_RECAL)    ? {26'h0000000, cal_req_q} :
    (avs_address == `TSTC_IDX_REPEAT)   ? {26'h0000000, repeat_q} :
    (avs_address == `TSTC_IDX_STATUS)   ? {24'h000000, recal_active, afe_low_power, 1'b0} :
    rd_cal  ? {22'h000000, cal_code_q[rd_ix]} :
    rd_meas ? {16'h0000, meas_q[rd_ix]} : 32'h00000000;
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // one wait cycle per access, read data captured with the answer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (avs_read & wait_q) ? rd_mux : rdata_q;
    end
  end

  // configuration registers; a software write beats a hardware clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      include_q  <= 6'(`TSTC_RST_INCLUDE);
      hold_q     <= 4'(`TSTC_RST_HOLD);
      sampling_q <= 7'(`TSTC_RST_SAMPLING);
      cal_req_q  <= 6'(`TSTC_RST_RECAL);
      repeat_q   <= 6'(`TSTC_RST_REPEAT);
    end
    else if (bus_wr && (avs_address == `TSTC_IDX_RECAL))
      cal_req_q <= avs_writedata[5:0];
    else
    begin
      cal_req_q <= cal_req_q & ~rc_clr;
      if (bus_wr && (avs_address == `TSTC_IDX_INCLUDE))
        include_q <= avs_writedata[5:0];
      if (bus_wr && (avs_address == `TSTC_IDX_HOLD))
        hold_q <= avs_writedata[`TSTC_HOLD_MSB:0];
      if (bus_wr && (avs_address == `TSTC_IDX_SAMPLING))
        sampling_q <= avs_writedata[6:0];
      if (bus_wr && (avs_address == `TSTC_IDX_REPEAT))
        repeat_q <= avs_writedata[5:0];
    end
  end

  // ---------------- sampling sequencer ----------------
  tstc_state_t state_q;
  logic [2:0]  chan_q;               // input being sampled
  logic [7:0]  rep_q;                // samples done on this input
  logic [9:0]  stick_q;              // ticks into this sample
  logic [22:0] acc_q;                // sample sum
  logic [19:0] cyc_q;                // ticks since cycle start
  logic        go_q;
  logic        lp_q;
  logic        mv_q;
  logic [2:0]  mch_q;
  logic [15:0] mval_q;
  logic [2:0]  avg_f;
  logic        samp_end;             // last tick of a sample
  logic        chan_end;             // last sample of this input
  logic [22:0] acc_sum;
  logic [3:0]  first_ch;             // first included input
  logic [3:0]  next_ch;              // next included input after this
  logic        cyc_over;             // cycle period used up
  logic [19:0] cyc_inc;

  assign avg_f    = sampling_q[`TSTC_AVG_MSB:`TSTC_AVG_LSB];
  assign samp_end = tick && (stick_q == samp_ticks(sampling_q[`TSTC_SAMP_MSB:`TSTC_SAMP_LSB])
                    - 10'h001);
  assign chan_end = samp_end && (rep_q == 8'((9'h001 << avg_f) - 9'h001));
  assign acc_sum  = acc_q + {7'h00, afe_sample_value};
  assign first_ch = first_from(include_q, 4'h0);
  assign next_ch  = first_from(include_q, {1'b0, chan_q} + 4'h1);
  assign cyc_inc  = (cyc_q == 20'hFFFFF) ? cyc_q : cyc_q + 20'h00001;
  assign cyc_over = (cyc_inc >= cyc_limit(sampling_q[`TSTC_CYC_MSB:`TSTC_CYC_LSB]));
  assign afe_sample_go = go_q;
  assign afe_channel   = chan_q;
  assign afe_low_power = lp_q;
  assign meas_valid    = mv_q;
  assign meas_channel  = mch_q;
  assign meas_value    = mval_q;

  // cycle: included inputs back to back, then low power until period ends; a period already used up restarts at once
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_q <= ST_LOWPWR;
      chan_q  <= 3'h0;
      rep_q   <= 8'h00;
      stick_q <= 10'h000;
      acc_q   <= 23'h000000;
      cyc_q   <= 20'h00000;
      go_q    <= 1'b0;
      lp_q    <= 1'b1;
      mv_q    <= 1'b0;
      mch_q   <= 3'h0;
      mval_q  <= 16'h0000;
    end
    else
    begin
      go_q <= 1'b0;
      mv_q <= 1'b0;
      if (tick)
        cyc_q <= cyc_inc;
      case (state_q)
        ST_SAMPLE:
        begin
          if (tick)
            stick_q <= samp_end ? 10'h000 : stick_q + 10'h001;
          if (samp_end)
          begin
            acc_q <= chan_end ? 23'h000000 : acc_sum;
            rep_q <= chan_end ? 8'h00 : rep_q + 8'h01;
            go_q  <= 1'b1;
          end
          if (chan_end)
          begin
            mv_q   <= 1'b1;
            mch_q  <= chan_q;
            mval_q <= 16'(acc_sum >> avg_f);
            if (next_ch[3])
              chan_q <= next_ch[2:0];
            else if (cyc_over)
            begin
              cyc_q  <= 20'h00000;
              chan_q <= first_ch[2:0];
              go_q   <= first_ch[3];
              state_q <= first_ch[3] ? ST_SAMPLE : ST_LOWPWR;
              lp_q    <= ~first_ch[3];
            end
            else
            begin
              go_q    <= 1'b0;
              state_q <= ST_LOWPWR;
              lp_q    <= 1'b1;
            end
          end
        end
        ST_LOWPWR:
        begin
          if (tick && cyc_over)
          begin
            cyc_q   <= 20'h00000;
            chan_q  <= first_ch[2:0];
            rep_q   <= 8'h00;
            stick_q <= 10'h000;
            acc_q   <= 23'h000000;
            go_q    <= first_ch[3];
            state_q <= first_ch[3] ? ST_SAMPLE : ST_LOWPWR;
            lp_q    <= ~first_ch[3];
          end
        end
        default:
          state_q <= ST_LOWPWR;
      endcase
    end
  end

  // averaged results kept per input
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      for (int i = 0; i < 6; i++)
        meas_q[i] <= 16'h0000;
    else if (chan_end)
      meas_q[chan_q] <= 16'(acc_sum >> avg_f);
  end

  // ---------------- recalibration engine ----------------
  logic        rc_busy_q;
  logic [2:0]  rc_ch_q;
  logic        rc_bad_q;             // press seen during this attempt
  logic [16:0] rc_tmr_q;             // ticks into attempt
  logic        rc_start_q;
  logic [5:0]  rc_act_q;
  logic [3:0]  rc_pick;
  logic        rc_timeout;
  logic        rc_end;
  logic        rc_ok;
  logic        rc_press;

  assign rc_pick    = first_from(cal_req_q, 4'h0);
  assign rc_press   = pad_touch[rc_ch_q];
  assign rc_timeout = tick && (rc_tmr_q == 17'(`TSTC_RECAL_MAX_TK - 1));
  assign rc_end     = rc_busy_q && (afe_cal_done || rc_timeout);
  assign rc_ok      = rc_busy_q && afe_cal_done && !rc_bad_q && !rc_press;
  assign rc_clr     = rc_ok ? 6'(6'h01 << rc_ch_q) : 6'h00;
  assign afe_cal_start   = rc_start_q;
  assign afe_cal_channel = rc_ch_q;
  assign recal_active    = rc_act_q;

  // one input at a time, lowest requested first; failures retry
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rc_busy_q  <= 1'b0;
      rc_ch_q    <= 3'h0;
      rc_bad_q   <= 1'b0;
      rc_tmr_q   <= 17'h00000;
      rc_start_q <= 1'b0;
      rc_act_q   <= 6'h00;
    end
    else
    begin
      rc_start_q <= 1'b0;
      if (!rc_busy_q)
      begin
        if (rc_pick[3])
        begin
          rc_busy_q  <= 1'b1;
          rc_ch_q    <= rc_pick[2:0];
          rc_bad_q   <= 1'b0;
          rc_tmr_q   <= 17'h00000;
          rc_start_q <= 1'b1;
          rc_act_q   <= 6'(6'h01 << rc_pick[2:0]);
        end
      end
      else if (rc_end)
      begin
        rc_busy_q <= 1'b0;
        rc_act_q  <= 6'h00;
      end
      else
      begin
        if (rc_press)
          rc_bad_q <= 1'b1;
        if (tick)
          rc_tmr_q <= rc_tmr_q + 17'h00001;
      end
    end
  end

  // calibration code updated on success only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      for (int i = 0; i < 6; i++)
        cal_code_q[i] <= 10'h000;
    else if (rc_ok)
      cal_code_q[rc_ch_q] <= afe_cal_code;
  end

  // ---------------- touch and hold classification ----------------
  logic [5:0]  eff_touch;            // touches not masked by recal
  logic [5:0]  prev_q;
  logic [16:0] held_q [6];           // ticks the touch has lasted
  logic [5:0]  tev_q;
  logic [5:0]  hev_q;
  logic [16:0] hlim;

  assign eff_touch   = pad_touch & ~rc_act_q;
  assign hlim        = hold_limit(hold_q);
  assign touch_event = tev_q;
  assign hold_event  = hev_q;

  // press, hold crossing and release per input
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      prev_q <= 6'h00;
      tev_q  <= 6'h00;
      hev_q  <= 6'h00;
      for (int i = 0; i < 6; i++)
        held_q[i] <= 17'h00000;
    end
    else
    begin
      prev_q <= eff_touch;
      for (int i = 0; i < 6; i++)
      begin
        tev_q[i] <= 1'b0;
        hev_q[i] <= 1'b0;
        if (eff_touch[i] && !prev_q[i])
        begin
          held_q[i] <= 17'h00000;
          tev_q[i]  <= ~repeat_q[i];
        end
        else if (eff_touch[i] && tick && (held_q[i] <= hlim))
        begin
          held_q[i] <= held_q[i] + 17'h00001;
          hev_q[i]  <= repeat_q[i] && (held_q[i] == hlim);
        end
        else if (!eff_touch[i] && prev_q[i])
          tev_q[i] <= repeat_q[i] && (held_q[i] <= hlim);
      end
    end
  end

  // ---------------- checks ----------------
  sequence s_req_wait;
    req && wait_q;
  endsequence
  sequence s_answer;
    !wait_q;
  endsequence
  chk_bus_answer_next: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_req_wait |=> s_answer)
    else $error("bus answer not one cycle after request");
  chk_hold_needs_rpt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    |hev_q |-> ((hev_q & ~$past(repeat_q)) == 6'h00))
    else $error("hold event on input without repeat");
  chk_hold_after_lim: assert property (@(posedge clk_sys) disable iff (!rst_b)
    hev_q[1] |-> (held_q[1] == $past(hlim) + 17'h00001))
    else $error("hold event not just past the limit");
  chk_meas_in_samp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mv_q |-> ($past(state_q) == ST_SAMPLE) && $past(samp_end))
    else $error("result outside sampling");
  chk_lowpwr_early: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(lp_q) && (cyc_q != 20'h00000) |-> $past(!cyc_over))
    else $error("low power entered after cycle period");
  chk_recal_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rc_busy_q |-> (rc_tmr_q < 17'(`TSTC_RECAL_MAX_TK)))
    else $error("recalibration beyond limit");
  chk_recal_press: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rc_busy_q && !rc_end && rc_press |=> rc_bad_q || !rc_busy_q)
    else $error("press during recal not recorded");
  chk_req_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !$past(bus_wr) && |($past(cal_req_q) & ~cal_req_q) |-> $past(rc_ok))
    else $error("request bit cleared without success");
  chk_code_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rc_ok |=> (cal_code_q[$past(rc_ch_q)] == $past(afe_cal_code)))
    else $error("calibration code not updated");
endmodule
`default_nettype wire

// ### tb/tstc_afe_model.sv
// behavioural model of the analog front end
`default_nettype none
module tstc_afe_model #(
  parameter int CAL_DLY = 400
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        afe_sample_go,
  input  wire logic [2:0]  afe_channel,
  input  wire logic        afe_low_power,
  input  wire logic        afe_cal_start,
  input  wire logic [9:0]  next_code,
  output logic      [15:0] afe_sample_value,
  output logic             afe_cal_done,
  output logic      [9:0]  afe_cal_code
);
  timeunit 1ns;
  timeprecision 1ps;
  int         k;     // sample index within one input
  int         cnt;   // cycles left of a recalibration
  logic       fresh; // a new polling cycle has begun
  logic [2:0] ch_q;  // input of the previous sample
  // value ramps by 2 per sample; code not valid outside the done pulse
  always @(posedge clk_sys)
  begin
    afe_cal_done <= 1'b0;
    afe_cal_code <= ~afe_cal_code;
    if (!rst_b)
    begin
      k = 0;
      cnt = 0;
      fresh = 1'b1;
      afe_sample_value <= 16'h0000;
      afe_cal_code <= 10'h155;
    end
    else
    begin
      if (afe_low_power)
        fresh = 1'b1;
      if (afe_sample_go)
      begin
        k = (fresh || afe_channel != ch_q) ? 0 : k + 1;
        fresh = 1'b0;
        ch_q = afe_channel;
        afe_sample_value <= {1'b0, afe_channel, 12'h000} + 16'(2 * k);
      end
      else if (afe_low_power)
        afe_sample_value <= ~afe_sample_value;
      // recalibration answered after a fixed delay
      if (afe_cal_start)
        cnt = CAL_DLY;
      else if (cnt > 0)
      begin
        cnt = cnt - 1;
        if (cnt == 0)
        begin
          afe_cal_done <= 1'b1;
          afe_cal_code <= next_code;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/touch_sampling_timing_ctrl_tb.sv
// self-checking bench for the touch sampling timing controller
`default_nettype none
`include "tstc_regs.svh"
module touch_sampling_timing_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 2;   // clocks per tick
  localparam int CD = 400; // recal answer delay
  logic        clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, lp_prev;
  logic        afe_cal_done, afe_sample_go, afe_low_power, afe_cal_start, meas_valid;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seed;
  logic [5:0]  pad_touch, recal_active, touch_event, hold_event;
  logic [15:0] afe_sample_value, meas_value;
  logic [9:0]  afe_cal_code, next_code;
  logic [2:0]  afe_channel, afe_cal_channel, meas_channel;
  int          error_cnt, total_checks, cyc, go_t, go_gap, lp_t, lp_gap, hold_at, n, m;
  int          tcnt[6], hcnt[6];
  wire         lp_fell = lp_prev & ~afe_low_power;

  tstc_core #(.TICK_CYC(TK)) tstc_core_i (.clk_sys, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pad_touch,
    .afe_sample_value, .afe_cal_done, .afe_cal_code, .afe_sample_go, .afe_channel,
    .afe_low_power, .afe_cal_start, .afe_cal_channel, .recal_active, .meas_valid,
    .meas_channel, .meas_value, .touch_event, .hold_event);
  tstc_afe_model #(.CAL_DLY(CD)) tstc_afe_model_i (.clk_sys, .rst_b, .afe_sample_go,
    .afe_channel, .afe_low_power, .afe_cal_start, .next_code, .afe_sample_value,
    .afe_cal_done, .afe_cal_code);

  // clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // gaps between sample starts and cycle starts, event counts
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    lp_prev <= afe_low_power;
    if (afe_sample_go === 1'b1)
    begin
      go_gap <= cyc - go_t;
      go_t <= cyc;
    end
    if (lp_fell === 1'b1)
    begin
      lp_gap <= cyc - lp_t;
      lp_t <= cyc;
    end
    for (int i = 0; i < 6; i++)
    begin
      tcnt[i] <= tcnt[i] + int'(touch_event[i] === 1'b1);
      hcnt[i] <= hcnt[i] + int'(hold_event[i] === 1'b1);
    end
    if (hold_event[1] === 1'b1)
      hold_at <= cyc;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // averaged value of the model's ramp
  function automatic logic [31:0] exp_avg(input int ch, input int sample_count_select);
    return 32'(ch * 4096 + (1 << sample_count_select) - 1);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one Avalon access; holds until waitrequest sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50)
      chk(32'h0, 32'h1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // 0 result, 1 recal start, 2 cycle start
  task automatic wait_for(input int w, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk_sys);
      if ((w == 0 && meas_valid === 1'b1) || (w == 1 && afe_cal_start === 1'b1)
          || (w == 2 && lp_fell === 1'b1))
        return;
    end
    chk(32'(w), 32'hFF);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end

  initial
  begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    pad_touch = 6'h00;
    next_code = 10'h000;
    seed = 32'd89601;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(`TSTC_IDX_HOLD, 32'h07);
    rchk(`TSTC_IDX_SAMPLING, 32'h39);
    rchk(`TSTC_IDX_RECAL, 32'h00);
    rchk(`TSTC_IDX_INCLUDE, 32'h3F);
    rchk(`TSTC_IDX_REPEAT, 32'h3F);
    rchk(8'h7F, 32'h0);
    seed = xs(seed);
    bus(1'b1, `TSTC_IDX_HOLD, {seed[31:4], 4'h0});
    rchk(`TSTC_IDX_HOLD, 32'h00);
    bus(1'b1, `TSTC_IDX_REPEAT, 32'h3E);
    bus(1'b1, `TSTC_IDX_INCLUDE, 32'h05);
    bus(1'b1, `TSTC_IDX_SAMPLING, 32'h10);
    $display("registers test done");
    wait_for(0, 40000);
    chk(meas_channel, 0);
    chk(meas_value, exp_avg(0, 1));
    chk(go_gap, 64 * TK);
    wait_for(0, 2000);
    chk(meas_channel, 2);
    chk(meas_value, exp_avg(2, 1));
    rchk(`TSTC_IDX_MEAS0 + 8'h02, exp_avg(2, 1));
    bus(1'b1, `TSTC_IDX_INCLUDE, 32'h01);
    bus(1'b1, `TSTC_IDX_SAMPLING, 32'h70);
    wait_for(2, 20000);
    // gap monitor updates on this edge; look one edge later
    @(posedge clk_sys);
    chk(lp_gap, 7000 * TK);
    $display("sampling test done");
    n = tcnt[0];
    @(posedge clk_sys) pad_touch <= 6'h01;
    repeat (20) @(posedge clk_sys);
    chk(tcnt[0], n + 1);
    seed = xs(seed);
    n = tcnt[1];
    m = hcnt[1];
    @(posedge clk_sys) pad_touch <= 6'h02;
    repeat (100 + seed[9:0]) @(posedge clk_sys);
    pad_touch <= 6'h00;
    repeat (20) @(posedge clk_sys);
    chk(tcnt[1], n + 1);
    chk(hcnt[1], m);
    @(posedge clk_sys) pad_touch <= 6'h02;
    n = cyc;
    repeat (7000 * TK + 200) @(posedge clk_sys);
    pad_touch <= 6'h00;
    chk(hold_at - n > 7000 * TK && hold_at - n <= 7000 * TK + 12, 1);
    chk(hcnt[1], m + 1);
    $display("hold test done");
    wait_for(0, 20000);
    chk(meas_value, exp_avg(0, 7));
    repeat (3) @(posedge clk_sys);
    chk(afe_low_power, 0);
    bus(1'b1, `TSTC_IDX_SAMPLING, 32'h00);
    $display("overrun test done");
    seed = xs(seed);
    next_code <= seed[9:0];
    bus(1'b1, `TSTC_IDX_RECAL, 32'h04);
    wait_for(1, 40000);
    chk(afe_cal_channel, 2);
    chk(recal_active, 6'h04);
    n = tcnt[2];
    pad_touch <= 6'h04;
    repeat (100) @(posedge clk_sys);
    pad_touch <= 6'h00;
    // spoilt attempt ends after the model delay and is retried at once
    wait_for(1, CD + 20);
    rchk(`TSTC_IDX_RECAL, 32'h04);
    chk(tcnt[2], n);
    repeat (CD + 20) @(posedge clk_sys);
    rchk(`TSTC_IDX_RECAL, 32'h00);
    rchk(`TSTC_IDX_CALCODE0 + 8'h02, {22'h0, next_code});
    chk(recal_active, 0);
    $display("recalibration test done");
    // longest sample time, two samples per result
    bus(1'b1, `TSTC_IDX_SAMPLING, 32'h1C);
    wait_for(0, 20000);
    chk(meas_value, exp_avg(0, 1));
    chk(go_gap, 512 * TK);
    $display("sample time test done");
    close_out();
  end
endmodule
`default_nettype wire
